// ---- rtl/otpls_top.sv ----
/*
  Program and load sequencer for the one-time programmable fuse array, with APB registers and one interrupt.
  Assumes the fuse macro samples the strobes on this clock and returns read data before a load strobe ends.
*/
// Functional notes
// RL1: A 0-to-1 write of program control bit 0 starts programming.
// RL2: Program control bit 7 reads 1 while programming runs.
// RL3: Any write to load control starts a load from the fuse array; the code starts one only when the sequencer is idle (ST_IDLE).
// RL4: Load control bit 7 reads 1 while a load runs.
// RL5: Program strobe width is the 8-bit field times eight clocks, reset 0x40.
// RL6: Load strobe width is bits 3..0 in clocks, reset 0x03.
// RL7: Mode bit 7 set inhibits programming.
// RL8: Mode bit 6 picks automatic (0) or manual (1) address range.
// RL9: Mode bits 5..0 select the memory; register resets to 0x01.
// RL10: Manual mode starts at the 4-bit start address, reset 0x00.
// RL11: Manual mode ends at end address bits 3..0, reset 0x1F; with start above end the code runs on to the last address.
// RL12: Power-select to chip-select delay is a 4-bit clock count, reset 0x03.
// RL13: Busy flags clear once the whole strobe sequence has finished.
// RL14: Automatic mode covers the full range, ignoring start and end fields.
`timescale 1ns/1ps
module otpls_top #(
  parameter int unsigned ADDR_W = 5
) (
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_psel,
  input  wire logic                 i_penable,
  input  wire logic                 i_pwrite,
  input  wire logic [31:0]          i_paddr,
  input  wire logic [31:0]          i_pwdata,
  output logic                      o_pready,
  output logic [31:0]               o_prdata,
  output logic                      o_pslverr,
  input  wire logic [7:0]           i_program_data,
  input  wire logic [7:0]           i_array_rdata,
  output otpls_pkg::otpls_array_t   o_array,
  output logic [7:0]                o_load_data,
  output logic [ADDR_W-1:0]         o_load_addr,
  output logic                      o_load_valid,
  output logic                      o_irq
);
  localparam logic [ADDR_W-1:0] ADDR_LAST = '1;

  logic [6:0]                  prog_ctrl;
  logic [6:0]                  load_ctrl;
  logic [7:0]                  prog_pw;
  logic [7:0]                  load_pw;
  logic [7:0]                  mode;
  logic [7:0]                  start_addr;
  logic [7:0]                  end_addr;
  logic [7:0]                  ps2cs;
  logic [otpls_pkg::IRQ_W-1:0] irq_status;
  logic [otpls_pkg::IRQ_W-1:0] irq_mask;
  otpls_pkg::otpls_state_t     state;
  otpls_pkg::otpls_array_t     arr;
  logic                        op_prog;
  logic [ADDR_W-1:0]           addr;
  logic [ADDR_W-1:0]           last_addr;
  logic [otpls_pkg::CNT_W-1:0] cnt;
  logic [otpls_pkg::CNT_W-1:0] strobe_cycles;
  logic [otpls_pkg::CNT_W-1:0] delay_cycles;
  logic [ADDR_W-1:0]           first_addr;
  logic [ADDR_W-1:0]           range_end;
  logic                        setup;
  logic                        wr;
  logic [15:0]                 idx;
  logic                        idx_ok;
  logic                        hit;
  logic [7:0]                  rd_byte;
  logic                        prog_trig;
  logic                        start_prog;
  logic                        start_load;
  logic                        prog_busy;
  logic                        load_busy;
  logic [otpls_pkg::IRQ_W-1:0] ev;
  logic [otpls_pkg::IRQ_W-1:0] next_irq_status;

  assign setup  = i_psel && !i_penable;
  assign wr     = i_psel && i_penable && o_pready && i_pwrite;
  assign idx    = i_paddr[17:2];
  assign idx_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[31:18] == 14'h0000);
  assign prog_busy = (state != otpls_pkg::ST_IDLE) && op_prog;   // see RL2
  assign load_busy = (state != otpls_pkg::ST_IDLE) && !op_prog;  // see RL4

  always_comb begin
    hit     = idx_ok;
    rd_byte = 8'h00;
    case (idx)
      otpls_pkg::IDX_PROG_CTRL:  rd_byte = {prog_busy, prog_ctrl};
      otpls_pkg::IDX_LOAD_CTRL:  rd_byte = {load_busy, load_ctrl};
      otpls_pkg::IDX_PROG_PW:    rd_byte = prog_pw;
      otpls_pkg::IDX_LOAD_PW:    rd_byte = {4'h0, load_pw[3:0]};
      otpls_pkg::IDX_MODE:       rd_byte = mode;
      otpls_pkg::IDX_START_ADDR: rd_byte = {4'h0, start_addr[3:0]};
      otpls_pkg::IDX_END_ADDR:   rd_byte = end_addr;
      otpls_pkg::IDX_PS2CS:      rd_byte = {4'h0, ps2cs[3:0]};
      otpls_pkg::IDX_IRQ_STATUS: rd_byte = {5'h00, irq_status};
      otpls_pkg::IDX_IRQ_MASK:   rd_byte = {5'h00, irq_mask};
      default:                   hit = 1'b0;
    endcase
  end

  // The answer is prepared in the setup cycle so that every bus output comes from a flip-flop.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else if (setup) begin
      o_pready  <= 1'b1;
      o_prdata  <= (hit && !i_pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      o_pslverr <= !hit;
    end else begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  assign prog_trig  = wr && idx_ok && (idx == otpls_pkg::IDX_PROG_CTRL)
                      && i_pwdata[otpls_pkg::BIT_TRIGGER] && !prog_ctrl[otpls_pkg::BIT_TRIGGER];  // see RL1
  assign start_prog = prog_trig && (state == otpls_pkg::ST_IDLE) && !mode[otpls_pkg::BIT_INHIBIT];  // see RL7
  assign start_load = wr && idx_ok && (idx == otpls_pkg::IDX_LOAD_CTRL)
                      && (state == otpls_pkg::ST_IDLE);  // see RL3

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prog_ctrl  <= otpls_pkg::RST_PROG_CTRL[6:0];
      load_ctrl  <= otpls_pkg::RST_LOAD_CTRL[6:0];
      prog_pw    <= otpls_pkg::RST_PROG_PW;
      load_pw    <= otpls_pkg::RST_LOAD_PW;
      mode       <= otpls_pkg::RST_MODE;
      start_addr <= otpls_pkg::RST_START_ADDR;
      end_addr   <= otpls_pkg::RST_END_ADDR;
      ps2cs      <= otpls_pkg::RST_PS2CS;
      irq_mask   <= otpls_pkg::RST_IRQ;
    end else if (wr && idx_ok) begin
      case (idx)
        otpls_pkg::IDX_PROG_CTRL:  prog_ctrl  <= i_pwdata[6:0];
        otpls_pkg::IDX_LOAD_CTRL:  load_ctrl  <= i_pwdata[6:0];
        otpls_pkg::IDX_PROG_PW:    prog_pw    <= i_pwdata[7:0];           // see RL5
        otpls_pkg::IDX_LOAD_PW:    load_pw    <= {4'h0, i_pwdata[3:0]};   // see RL6
        otpls_pkg::IDX_MODE:       mode       <= i_pwdata[7:0];           // see RL9
        otpls_pkg::IDX_START_ADDR: start_addr <= {4'h0, i_pwdata[3:0]};   // see RL10
        otpls_pkg::IDX_END_ADDR:   end_addr   <= i_pwdata[7:0];           // see RL11
        otpls_pkg::IDX_PS2CS:      ps2cs      <= {4'h0, i_pwdata[3:0]};   // see RL12
        otpls_pkg::IDX_IRQ_MASK:   irq_mask   <= i_pwdata[otpls_pkg::IRQ_W-1:0];
        default:                   prog_ctrl  <= prog_ctrl;
      endcase
    end
  end

  // A zero width or delay would give no strobe at all, so it is raised to the smallest unit.
  always_comb begin
    if (prog_pw == 8'h00) begin
      strobe_cycles = otpls_pkg::CNT_W'(otpls_pkg::PROG_PW_UNIT);
    end else begin
      strobe_cycles = otpls_pkg::CNT_W'(prog_pw) * otpls_pkg::CNT_W'(otpls_pkg::PROG_PW_UNIT);  // see RL5
    end
    if (!op_prog) begin
      strobe_cycles = (load_pw[3:0] == 4'h0) ? otpls_pkg::CNT_W'(1) : otpls_pkg::CNT_W'(load_pw[3:0]);  // see RL6
    end
    delay_cycles = (ps2cs[3:0] == 4'h0) ? otpls_pkg::CNT_W'(1) : otpls_pkg::CNT_W'(ps2cs[3:0]);  // see RL12
  end

  always_comb begin
    if (mode[otpls_pkg::BIT_MANUAL]) begin  // see RL8
      first_addr = ADDR_W'(start_addr[3:0]);  // see RL10
      range_end  = ADDR_W'(end_addr[3:0]);    // see RL11
    end else begin
      first_addr = '0;         // see RL14
      range_end  = ADDR_LAST;  // see RL14
    end
  end

  // The memory select and range are frozen at start so a mode or address write cannot bend a running sequence.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state     <= otpls_pkg::ST_IDLE;
      op_prog   <= 1'b0;
      addr      <= '0;
      last_addr <= '0;
      cnt       <= '0;
      arr       <= '{power_select_strobe: 1'b0, array_chip_select_low_n: 1'b1, default: '0};
    end else begin
      case (state)
        otpls_pkg::ST_IDLE: begin
          if (start_prog || start_load) begin
            state                   <= otpls_pkg::ST_POWER;
            op_prog                 <= start_prog;
            addr                    <= first_addr;
            last_addr               <= range_end;
            cnt                     <= delay_cycles - otpls_pkg::CNT_W'(1);
            arr.power_select_strobe <= 1'b1;
            arr.mem_sel             <= mode[5:0];  // see RL9
          end
        end
        otpls_pkg::ST_POWER: begin
          if (cnt == '0) begin
            state                       <= otpls_pkg::ST_STROBE;
            arr.array_chip_select_low_n <= 1'b0;  // see RL12
            arr.addr                    <= addr;
            arr.wdata                   <= i_program_data;
            arr.prog_strobe             <= op_prog;
            arr.load_strobe             <= !op_prog;
            cnt                         <= strobe_cycles - otpls_pkg::CNT_W'(1);
          end else begin
            cnt <= cnt - otpls_pkg::CNT_W'(1);
          end
        end
        otpls_pkg::ST_STROBE: begin
          if (cnt == '0) begin
            state           <= otpls_pkg::ST_GAP;  // see RL5
            arr.prog_strobe <= 1'b0;
            arr.load_strobe <= 1'b0;
          end else begin
            cnt <= cnt - otpls_pkg::CNT_W'(1);
          end
        end
        otpls_pkg::ST_GAP: begin
          if (addr == last_addr || addr == ADDR_LAST) begin
            state                       <= otpls_pkg::ST_DONE;
            arr.array_chip_select_low_n <= 1'b1;
          end else begin
            state           <= otpls_pkg::ST_STROBE;
            addr            <= addr + ADDR_W'(1);
            arr.addr        <= addr + ADDR_W'(1);
            arr.wdata       <= i_program_data;
            arr.prog_strobe <= op_prog;
            arr.load_strobe <= !op_prog;
            cnt             <= strobe_cycles - otpls_pkg::CNT_W'(1);
          end
        end
        otpls_pkg::ST_DONE: begin
          state                   <= otpls_pkg::ST_IDLE;  // see RL13
          arr.power_select_strobe <= 1'b0;
        end
        default: state <= otpls_pkg::ST_IDLE;
      endcase
    end
  end

  assign o_array = arr;

  // Read data is taken on the last strobe cycle, when the array output has settled longest.
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_load_data  <= 8'h00;
      o_load_addr  <= '0;
      o_load_valid <= 1'b0;
    end else begin
      o_load_valid <= (state == otpls_pkg::ST_STROBE) && (cnt == '0) && !op_prog;
      if ((state == otpls_pkg::ST_STROBE) && (cnt == '0) && !op_prog) begin
        o_load_data <= i_array_rdata;
        o_load_addr <= addr;
      end
    end
  end

  always_comb begin
    ev                           = '0;
    ev[otpls_pkg::IRQ_PROG_DONE] = (state == otpls_pkg::ST_DONE) && op_prog;
    ev[otpls_pkg::IRQ_LOAD_DONE] = (state == otpls_pkg::ST_DONE) && !op_prog;
    ev[otpls_pkg::IRQ_REFUSED]   = prog_trig && !start_prog;
    next_irq_status = irq_status;
    if (wr && idx_ok && idx == otpls_pkg::IDX_IRQ_STATUS) begin
      next_irq_status = irq_status & ~i_pwdata[otpls_pkg::IRQ_W-1:0];
    end
    next_irq_status = next_irq_status | ev;
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_status <= otpls_pkg::RST_IRQ;
      o_irq      <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      o_irq      <= |(irq_status & irq_mask);
    end
  end

  logic [otpls_pkg::CNT_W-1:0] chk_len;
  logic [otpls_pkg::CNT_W-1:0] chk_ps;
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      chk_len <= '0;
      chk_ps  <= '0;
    end else begin
      chk_len <= (arr.prog_strobe || arr.load_strobe) ? chk_len + otpls_pkg::CNT_W'(1) : '0;
      chk_ps  <= (arr.power_select_strobe && arr.array_chip_select_low_n) ? chk_ps + otpls_pkg::CNT_W'(1) : '0;
    end
  end

  property p_prog_start;
    @(posedge i_mclk) disable iff (!i_rst_n)
      start_prog |=> prog_busy && arr.power_select_strobe;
  endproperty
  a_prog_start: assert property (p_prog_start) else $error("program did not start on trigger");  // see RL1

  property p_prog_busy;
    @(posedge i_mclk) disable iff (!i_rst_n)
      arr.prog_strobe |-> prog_busy;
  endproperty
  a_prog_busy: assert property (p_prog_busy) else $error("program strobe without busy flag");  // see RL2

  property p_load_start;
    @(posedge i_mclk) disable iff (!i_rst_n)
      start_load |=> load_busy ##1 load_busy;
  endproperty
  a_load_start: assert property (p_load_start) else $error("load did not start on write");  // see RL3 RL4

  property p_strobe_width;
    @(posedge i_mclk) disable iff (!i_rst_n)
      $fell(arr.prog_strobe || arr.load_strobe) |-> chk_len == strobe_cycles;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe width wrong");  // see RL5 RL6

  property p_inhibit;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (prog_trig && mode[otpls_pkg::BIT_INHIBIT]) |=> !prog_busy && irq_status[otpls_pkg::IRQ_REFUSED];
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibited program ran");  // see RL7

  property p_first_addr;
    @(posedge i_mclk) disable iff (!i_rst_n)
      $fell(arr.array_chip_select_low_n) |-> arr.addr == first_addr;
  endproperty
  a_first_addr: assert property (p_first_addr) else $error("first address wrong");  // see RL8 RL10 RL14

  property p_ps2cs;
    @(posedge i_mclk) disable iff (!i_rst_n)
      $fell(arr.array_chip_select_low_n) |-> chk_ps == delay_cycles;
  endproperty
  a_ps2cs: assert property (p_ps2cs) else $error("select delay wrong");  // see RL12

  property p_cs_in_ps;
    @(posedge i_mclk) disable iff (!i_rst_n)
      !arr.array_chip_select_low_n |-> arr.power_select_strobe;
  endproperty
  a_cs_in_ps: assert property (p_cs_in_ps) else $error("chip select outside power select");  // see RL12

  property p_done;
    @(posedge i_mclk) disable iff (!i_rst_n)
      (state == otpls_pkg::ST_DONE) |=> state == otpls_pkg::ST_IDLE && !prog_busy && !load_busy
        && ev == '0 && next_irq_status[otpls_pkg::IRQ_PROG_DONE] | next_irq_status[otpls_pkg::IRQ_LOAD_DONE];
  endproperty
  a_done: assert property (p_done) else $error("busy not cleared at completion");  // see RL13

  property p_last_addr;
    @(posedge i_mclk) disable iff (!i_rst_n)
      $rose(arr.array_chip_select_low_n) |-> $past(arr.addr) == last_addr || $past(arr.addr) == ADDR_LAST;
  endproperty
  a_last_addr: assert property (p_last_addr) else $error("sequence ended at wrong address");  // see RL11 RL13

  property p_irq;
    @(posedge i_mclk) disable iff (!i_rst_n)
      ##1 o_irq == $past(|(irq_status & irq_mask));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output mismatch");
endmodule

// ---- rtl/otpls_pkg.sv ----
/*
  Constants, types and register map of the fuse memory program/load sequencer.
  Assumes an APB slave with 32-bit data; each register sits at byte address four times its index.
*/
package otpls_pkg;
  localparam logic [15:0] IDX_PROG_CTRL  = 16'h3d80;
  localparam logic [15:0] IDX_LOAD_CTRL  = 16'h3d81;
  localparam logic [15:0] IDX_PROG_PW    = 16'h3d82;
  localparam logic [15:0] IDX_LOAD_PW    = 16'h3d83;
  localparam logic [15:0] IDX_MODE       = 16'h3d84;
  localparam logic [15:0] IDX_START_ADDR = 16'h3d85;
  localparam logic [15:0] IDX_END_ADDR   = 16'h3d86;
  localparam logic [15:0] IDX_PS2CS      = 16'h3d87;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h3d88;
  localparam logic [15:0] IDX_IRQ_MASK   = 16'h3d89;

  localparam logic [7:0] RST_PROG_CTRL  = 8'h00;
  localparam logic [7:0] RST_LOAD_CTRL  = 8'h00;
  localparam logic [7:0] RST_PROG_PW    = 8'h40;
  localparam logic [7:0] RST_LOAD_PW    = 8'h03;
  localparam logic [7:0] RST_MODE       = 8'h01;
  localparam logic [7:0] RST_START_ADDR = 8'h00;
  localparam logic [7:0] RST_END_ADDR   = 8'h1f;
  localparam logic [7:0] RST_PS2CS      = 8'h03;
  localparam logic [2:0] RST_IRQ        = 3'h0;

  localparam int BIT_TRIGGER  = 0;
  localparam int BIT_BUSY     = 7;
  localparam int BIT_INHIBIT  = 7;
  localparam int BIT_MANUAL   = 6;
  localparam int IRQ_PROG_DONE = 0;
  localparam int IRQ_LOAD_DONE = 1;
  localparam int IRQ_REFUSED   = 2;
  localparam int IRQ_W         = 3;

  localparam int          PROG_PW_UNIT = 8;
  localparam int          CNT_W        = 12;
  localparam int          CLK_MHZ      = 200;
  localparam real         CLK_NS       = 5.0;

  typedef enum logic [2:0] {ST_IDLE, ST_POWER, ST_STROBE, ST_GAP, ST_DONE} otpls_state_t;

  typedef struct packed {
    logic       power_select_strobe;
    logic       array_chip_select_low_n;
    logic       prog_strobe;
    logic       load_strobe;
    logic [4:0] addr;
    logic [5:0] mem_sel;
    logic [7:0] wdata;
  } otpls_array_t;
endpackage

// ---- bench/otpls_fuse_model.sv ----
/*
  Behavioural model of the fuse array that sits behind the sequencer.
  Assumes the strobes and address arrive registered on the system clock.
*/
`timescale 1ns/1ps
module otpls_fuse_model (
  input  wire logic                    i_mclk,
  input  wire otpls_pkg::otpls_array_t i_array,
  output logic [7:0]                   o_rdata
);
  logic [7:0] mem [32];
  logic [7:0] last_q;
  logic       prog_q;

  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = 8'h5a ^ 8'(i * 3);
    end
    last_q = 8'h00;
    prog_q = 1'b0;
  end

  // An unselected array does not hold its last byte, so the bus toggles every cycle instead.
  assign o_rdata = (!i_array.array_chip_select_low_n && i_array.load_strobe) ? mem[i_array.addr] : ~last_q;

  always @(posedge i_mclk) begin
    // Fuses can only be blown, so programmed bits are OR-ed into the stored byte.
    if (!i_array.array_chip_select_low_n && i_array.prog_strobe && !prog_q) begin
      mem[i_array.addr] <= mem[i_array.addr] | i_array.wdata;
    end
    prog_q <= i_array.prog_strobe;
    last_q <= o_rdata;
  end
endmodule

// ---- bench/otp_program_load_sequencer_tb_top.sv ----
/*
  Self-checking bench for the fuse sequencer: APB register traffic, loads, programs and the interrupt.
  Assumes the fuse model above on the array side and a zero-wait-state APB slave.
*/
`timescale 1ns/1ps
module otp_program_load_sequencer_tb_top;
  logic i_mclk, i_rst_n, psel, penable, pwrite;
  logic [31:0] paddr, pwdata, o_prdata;
  logic o_pready, o_pslverr, o_load_valid, o_irq;
  logic [7:0] pdata, rdata, o_load_data;
  logic [4:0] o_load_addr;
  otpls_pkg::otpls_array_t o_array;
  int error_cnt = 0, samples_checked = 0;
  int ps_cnt = 0, d_meas = 0, st_cnt = 0, w_meas = 0, n_str = 0, n_ps = 0, n0;
  logic ps_q = 1'b0;
  logic [5:0] sel_meas;
  logic [12:0] exp_ld[$];
  logic [7:0] exp_mem [32];
  logic [31:0] rd;
  logic er;
  logic [7:0] lw, dl, pd;
  logic [5:0] sel;
  logic [15:0] ridx[8] = '{16'h3d80, 16'h3d81, 16'h3d82, 16'h3d83, 16'h3d84, 16'h3d85, 16'h3d86, 16'h3d87};
  logic [7:0]  rval[8] = '{8'h00, 8'h00, 8'h40, 8'h03, 8'h01, 8'h00, 8'h1f, 8'h03};

  otpls_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .i_program_data(pdata), .i_array_rdata(rdata), .o_array(o_array), .o_load_data(o_load_data),
    .o_load_addr(o_load_addr), .o_load_valid(o_load_valid), .o_irq(o_irq));
  otpls_fuse_model fuse (.i_mclk(i_mclk), .i_array(o_array), .o_rdata(rdata));

  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
    int n;
    @(posedge i_mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {14'h0, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge i_mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_pready !== 1'b1 && n < 50);
    rd = o_prdata;
    er = o_pslverr;
    if (n >= 50) check(32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle(input logic [15:0] idx);
    for (int k = 0; k < 400; k++) begin
      apb(1'b0, idx, 8'h00);
      if (rd[7] === 1'b0) break;
    end
    check(rd[7], 32'h0);
  endtask

  task automatic run_load(input int first, input int last_a);
    for (int a = first; a <= last_a; a++) exp_ld.push_back({5'(a), exp_mem[a]});
    apb(1'b1, otpls_pkg::IDX_LOAD_CTRL, 8'h00);
    apb(1'b0, otpls_pkg::IDX_LOAD_CTRL, 8'h00);
    check(rd[7], 32'h1);
    wait_idle(otpls_pkg::IDX_LOAD_CTRL);
    check(exp_ld.size(), 32'h0);
  endtask

  // Result monitor: every loaded byte retires the oldest expectation.
  always @(posedge i_mclk) begin
    if (o_load_valid === 1'b1) begin
      if (exp_ld.size() == 0) check(32'h0, 32'h1);
      else check({o_load_addr, o_load_data}, exp_ld.pop_front());
    end
    if (o_array.power_select_strobe && !ps_q) n_ps++;
    ps_q = o_array.power_select_strobe;
    if (o_array.power_select_strobe && o_array.array_chip_select_low_n) ps_cnt++;
    else if (!o_array.array_chip_select_low_n && ps_cnt != 0) begin
      d_meas = ps_cnt;
      ps_cnt = 0;
      sel_meas = o_array.mem_sel;
    end
    if (!o_array.power_select_strobe) ps_cnt = 0;
    if (o_array.prog_strobe || o_array.load_strobe) st_cnt++;
    else if (st_cnt != 0) begin
      w_meas = st_cnt;
      st_cnt = 0;
      n_str++;
    end
  end

  initial begin
    #200us;
    error_cnt++;
    tally_and_finish;
  end

  initial begin
    i_rst_n = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 32'h0;
    pwdata = 32'h0;
    pdata = 8'h00;
    for (int i = 0; i < 32; i++) exp_mem[i] = 8'h5a ^ 8'(i * 3);
    void'($urandom(32'h9480));
    repeat (8) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, ridx[i], 8'h00);
      check(rd, {24'h0, rval[i]});
    end
    apb(1'b0, 16'h3d8a, 8'h00);
    check({31'h0, er}, 32'h1);
    check(rd, 32'h0);
    // Manual single-address load with default delay and width.
    apb(1'b1, otpls_pkg::IDX_MODE, 8'h41);
    apb(1'b1, otpls_pkg::IDX_START_ADDR, 8'h02);
    apb(1'b1, otpls_pkg::IDX_END_ADDR, 8'h02);
    n0 = n_str;
    run_load(2, 2);
    check(d_meas, 32'd3);
    check(w_meas, 32'd3);
    check(n_str - n0, 32'd1);
    // Manual program of addresses 4 to 6 with the shortest strobe.
    pd = 8'($urandom);
    pdata <= pd;
    apb(1'b1, otpls_pkg::IDX_PROG_PW, 8'h01);
    apb(1'b1, otpls_pkg::IDX_START_ADDR, 8'h04);
    apb(1'b1, otpls_pkg::IDX_END_ADDR, 8'h06);
    n0 = n_str;
    apb(1'b1, otpls_pkg::IDX_PROG_CTRL, 8'h01);
    apb(1'b0, otpls_pkg::IDX_PROG_CTRL, 8'h00);
    check(rd, 32'h81);
    wait_idle(otpls_pkg::IDX_PROG_CTRL);
    check(w_meas, 32'd8);
    check(n_str - n0, 32'd3);
    for (int a = 4; a <= 6; a++) exp_mem[a] = exp_mem[a] | pd;
    // Bit 0 is still set, so writing it as one again is no rising transition and must not start anything.
    n0 = n_ps;
    apb(1'b1, otpls_pkg::IDX_PROG_CTRL, 8'h01);
    repeat (2) @(posedge i_mclk);
    check(n_ps - n0, 32'd0);
    apb(1'b1, otpls_pkg::IDX_PROG_CTRL, 8'h00);
    // Automatic load of the whole array with random width, delay and memory select.
    lw = 8'(1 + $urandom % 15);
    dl = 8'(1 + $urandom % 15);
    sel = 6'($urandom);
    apb(1'b1, otpls_pkg::IDX_LOAD_PW, lw);
    apb(1'b1, otpls_pkg::IDX_PS2CS, dl);
    apb(1'b1, otpls_pkg::IDX_MODE, {2'b00, sel});
    run_load(0, 31);
    check(w_meas, lw);
    check(d_meas, dl);
    check(sel_meas, sel);
    // Inhibited program is refused and raises the interrupt.
    apb(1'b1, otpls_pkg::IDX_IRQ_STATUS, 8'h07);
    apb(1'b1, otpls_pkg::IDX_IRQ_MASK, 8'h04);
    apb(1'b1, otpls_pkg::IDX_MODE, {2'b10, sel});
    n0 = n_ps;
    apb(1'b1, otpls_pkg::IDX_PROG_CTRL, 8'h01);
    apb(1'b0, otpls_pkg::IDX_IRQ_STATUS, 8'h00);
    check(rd, 32'h04);
    check(n_ps - n0, 32'd0);
    check(o_irq, 32'h1);
    apb(1'b1, otpls_pkg::IDX_IRQ_MASK, 8'h00);
    repeat (2) @(posedge i_mclk);
    check(o_irq, 32'h0);
    apb(1'b1, otpls_pkg::IDX_IRQ_STATUS, 8'h04);
    apb(1'b0, otpls_pkg::IDX_IRQ_STATUS, 8'h00);
    check(rd, 32'h0);
    tally_and_finish;
  end
endmodule
